//--- hw/bbrc_pkg.sv
// constants, field layout and timing for the buck-boost regulator control bank
package bbrc_pkg;
  // register byte addresses
  localparam logic [7:0] BBRC_OFF_ENABLE_CONTROL = 8'h40;
  localparam logic [7:0] BBRC_OFF_MAIN_CONFIG = 8'h41;
  localparam logic [7:0] BBRC_OFF_VOLTAGE_SETTING = 8'h42;
  localparam logic [7:0] BBRC_OFF_PEAK_CURRENT = 8'h43;
  localparam logic [7:0] BBRC_OFF_EXTRA_CONFIG = 8'h44;
  localparam logic [7:0] BBRC_OFF_PIN_ENABLE_MASK = 8'h45;
  localparam logic [7:0] BBRC_OFF_SCALING_PIN_SELECT = 8'h46;
  localparam logic [7:0] BBRC_OFF_ALT_VOLTAGE_ZERO = 8'h47;
  localparam logic [7:0] BBRC_OFF_APPLIED_READBACK = 8'h4b;
  localparam int BBRC_ALT_COUNT = 4;
  // writable bits per register, the rest read as zero
  localparam logic [7:0] BBRC_MAIN_CFG_MASK = 8'h9f;
  localparam logic [7:0] BBRC_EXTRA_CFG_MASK = 8'h7f;
  // main config field positions
  localparam int BBRC_BIT_LOOKUP_DIS = 7;
  localparam int BBRC_BIT_SLOW_EDGE = 4;
  localparam int BBRC_BIT_ACT_DSC = 3;
  localparam int BBRC_BIT_RAMP_EN = 2;
  localparam int BBRC_BIT_OP_MODE = 1;
  localparam int BBRC_BIT_PSV_DSC = 0;
  // extra config field positions, and the control pin that can drive fast mode
  localparam int BBRC_BIT_ADAPT_DIS = 6;
  localparam int BBRC_BIT_FAST = 5;
  localparam int BBRC_BIT_ZC_DIS = 4;
  localparam int BBRC_BIT_SW_HALF = 3;
  localparam int BBRC_BIT_PIN_FAST = 2;
  localparam int BBRC_PIN_FAST_SRC = 1;
  // boot slot codes
  localparam logic [2:0] BBRC_SLOT_OFF = 3'h0;
  localparam logic [2:0] BBRC_SLOT_AT_0 = 3'h2;
  localparam logic [2:0] BBRC_SLOT_AT_25 = 3'h3;
  localparam logic [2:0] BBRC_SLOT_AT_50 = 3'h4;
  localparam logic [2:0] BBRC_SLOT_SOFT = 3'h7;
  // enable select codes
  localparam logic [1:0] BBRC_SEL_OFF = 2'h0;
  localparam logic [1:0] BBRC_SEL_ON = 2'h1;
  localparam logic [1:0] BBRC_SEL_PINS = 2'h2;
  // voltage code scale
  localparam logic [5:0] BBRC_VCODE_MAX = 6'h3c;
  localparam int BBRC_VOUT_BASE_MV = 2500;
  localparam int BBRC_VOUT_STEP_MV = 50;
  // ramp step timing
  localparam int BBRC_CLK_PERIOD_NS = 10;
  localparam int BBRC_RAMP_STEP_US = 20;
  localparam int BBRC_RAMP_STEP_CYCLES = (BBRC_RAMP_STEP_US * 1000 + BBRC_CLK_PERIOD_NS - 1)
                                         / BBRC_CLK_PERIOD_NS;
  localparam logic [10:0] BBRC_RAMP_LAST = 11'(BBRC_RAMP_STEP_CYCLES - 1);
endpackage

//--- hw/bbrc_link_if.sv
// carrier between the control bank, the ramp stepper and the pin pair decoder
`timescale 1ns/1ns
interface bbrc_link_if;
  logic [5:0] target; // requested voltage code
  logic ramp_en; // stepped increases wanted
  logic [5:0] applied; // code handed to the power stage
  logic [4:0] pair_cfg; // scaling pin pair selection
  logic [7:0] pins; // control pin levels
  logic pair_active; // scaling in force
  logic [1:0] pair_level; // level of the chosen pair
  modport ctl(output target, ramp_en, pair_cfg, pins, input applied, pair_active, pair_level);
  modport ramp(input target, ramp_en, output applied);
  modport pair(input pair_cfg, pins, output pair_active, pair_level);
endinterface

//--- hw/bbrc_ramp.sv
// voltage code stepper: immediate moves or one code per step time upward
`timescale 1ns/1ns
module bbrc_ramp
  import bbrc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  bbrc_link_if.ramp lnk
);
  typedef enum logic {BBRC_RAMP_HOLD, BBRC_RAMP_STEP} bbrc_ramp_state_t;
  bbrc_ramp_state_t state_q; // stepping or following
  logic [5:0] applied_q; // code in force
  logic [10:0] tick_q; // cycles since last step

  // stepper; decreases and unramped moves land at once
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= BBRC_RAMP_HOLD;
      applied_q <= 6'h00;
      tick_q <= 11'h000;
    end else begin
      case (state_q)
        BBRC_RAMP_HOLD: begin
          tick_q <= 11'h000;
          if (lnk.ramp_en && (lnk.target > applied_q)) begin
            state_q <= BBRC_RAMP_STEP; // first step one full step time later
          end else begin
            applied_q <= lnk.target;
          end
        end
        BBRC_RAMP_STEP: begin
          if (!lnk.ramp_en || (lnk.target <= applied_q)) begin
            applied_q <= lnk.target;
            state_q <= BBRC_RAMP_HOLD;
          end else if (tick_q == BBRC_RAMP_LAST) begin
            applied_q <= applied_q + 6'h01;
            tick_q <= 11'h000;
          end else begin
            tick_q <= tick_q + 11'h001;
          end
        end
        default: state_q <= BBRC_RAMP_HOLD;
      endcase
    end
  end

  assign lnk.applied = applied_q;

  sequence s_step_due;
    (state_q == BBRC_RAMP_STEP) && (tick_q == BBRC_RAMP_LAST) && lnk.ramp_en
      && (lnk.target > applied_q);
  endsequence
  sequence s_one_up;
    (applied_q == $past(applied_q) + 6'h01) && (tick_q == 11'h000);
  endsequence
  property p_ramp_single_step;
    @(posedge mclk) disable iff (!rst_n) s_step_due |=> s_one_up;
  endproperty
  a_ramp_single_step: assert property (p_ramp_single_step)
    else $error("ramp step is not one code");
  property p_ramp_no_early_step;
    @(posedge mclk) disable iff (!rst_n)
      (state_q == BBRC_RAMP_STEP) && (tick_q != BBRC_RAMP_LAST) && lnk.ramp_en
        && (lnk.target > applied_q) |=> $stable(applied_q);
  endproperty
  a_ramp_no_early_step: assert property (p_ramp_no_early_step)
    else $error("ramp stepped before step time");
  property p_ramp_direct;
    @(posedge mclk) disable iff (!rst_n)
      !lnk.ramp_en |=> (applied_q == $past(lnk.target));
  endproperty
  a_ramp_direct: assert property (p_ramp_direct)
    else $error("unramped change not applied at once");
endmodule

//--- hw/bbrc_pair_decode.sv
// maps the scaling pin pair code onto two pins and their two-bit level
`timescale 1ns/1ns
module bbrc_pair_decode
  import bbrc_pkg::*;
(
  bbrc_link_if.pair lnk
);
  // pairs counted in ascending order from code one; anything past the last pair stays off
  always_comb begin
    int k;
    k = 1;
    lnk.pair_active = 1'b0;
    lnk.pair_level = 2'h0;
    for (int a = 0; a < 7; a++) begin
      for (int b = a + 1; b < 8; b++) begin
        if (lnk.pair_cfg == 5'(k)) begin
          lnk.pair_active = 1'b1;
          lnk.pair_level = {lnk.pins[b], lnk.pins[a]};
        end
        k = k + 1;
      end
    end
  end
endmodule

//--- hw/bbrc_top.sv
// buck-boost regulator control bank: registers, enable sourcing and stage controls
`timescale 1ns/1ns
module bbrc_top
  import bbrc_pkg::*;
#(
  parameter int unsigned BOOT_DELAY_CYCLES = 4000
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] boot_slot_strap,
  input wire logic [7:0] general_control_pin,
  input wire logic hard_reset_req,
  input wire logic off_mode_req,
  output logic reg_enable,
  output logic buck_only_mode,
  output logic slow_edge_mode,
  output logic active_discharge,
  output logic passive_discharge,
  output logic [5:0] voltage_code,
  output logic voltage_code_invalid,
  output logic [12:0] voltage_mv,
  output logic peak_from_table,
  output logic [3:0] nominal_peak_code,
  output logic [4:0] max_peak_code,
  output logic adaptive_disable,
  output logic valley_fixed_zero,
  output logic fast_mode,
  output logic zero_cross_disable,
  output logic switch_halving,
  output logic [1:0] freq_threshold,
  output logic dvs_active
);
  // reset release
  logic rst_meta_q; // first stage, read only by the second
  logic rst_n; // released reset for all logic

  // register fields
  logic [2:0] bb_boot_slot; // caught from the strap
  logic slot_caught_q; // strap has been taken
  logic [1:0] bb_enable_select; // software enable source
  logic [7:0] cfg_q; // main config
  logic [5:0] bb_voltage_code; // nominal voltage code
  logic [7:0] peak_q; // peak current nibbles
  logic [7:0] extra_q; // extra config
  logic [7:0] bb_pin_select_mask; // pins that may enable
  logic [4:0] bb_scaling_pin_pair; // scaling pair code
  logic [5:0] alt_q [BBRC_ALT_COUNT]; // alternate voltage codes
  logic [7:0] rdata_d; // read mux

  // boot timing
  logic [15:0] boot_cnt_q; // cycles since strap capture
  logic reach_25; // quarter of boot delay passed
  logic reach_50; // half of boot delay passed
  logic reach_100; // full boot delay passed

  // derived controls
  logic pin_or; // OR of masked pins
  logic en_d; // next regulator enable
  logic sel_off_soft; // software holds it off via code 00
  logic act_dsc_d; // next active discharge request
  logic psv_dsc_d; // next passive discharge request

  bbrc_link_if lnk();

  // two-flop release, assert is immediate
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // strap caught once, first clock after release; a reset constant cannot hold a port value
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bb_boot_slot <= BBRC_SLOT_OFF;
      slot_caught_q <= 1'b0;
    end else if (!slot_caught_q) begin
      bb_boot_slot <= boot_slot_strap;
      slot_caught_q <= 1'b1;
    end
  end

  // boot delay counter, saturates at the full delay
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      boot_cnt_q <= 16'h0000;
    end else if (slot_caught_q && !reach_100) begin
      boot_cnt_q <= boot_cnt_q + 16'h0001;
    end
  end

  assign reach_25 = boot_cnt_q >= 16'(BOOT_DELAY_CYCLES / 4);
  assign reach_50 = boot_cnt_q >= 16'(BOOT_DELAY_CYCLES / 2);
  assign reach_100 = boot_cnt_q >= 16'(BOOT_DELAY_CYCLES);

  // register writes; the boot slot field ignores writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bb_enable_select <= 2'h0;
      cfg_q <= 8'h00;
      bb_voltage_code <= 6'h00;
      peak_q <= 8'h00;
      extra_q <= 8'h00;
      bb_pin_select_mask <= 8'h00;
      bb_scaling_pin_pair <= 5'h00;
      for (int i = 0; i < BBRC_ALT_COUNT; i++) begin
        alt_q[i] <= 6'h00;
      end
    end else if (reg_wr_en) begin
      case (reg_addr)
        BBRC_OFF_ENABLE_CONTROL: bb_enable_select <= reg_wdata[1:0];
        BBRC_OFF_MAIN_CONFIG: cfg_q <= reg_wdata & BBRC_MAIN_CFG_MASK;
        BBRC_OFF_VOLTAGE_SETTING: bb_voltage_code <= reg_wdata[5:0];
        BBRC_OFF_PEAK_CURRENT: peak_q <= reg_wdata;
        BBRC_OFF_EXTRA_CONFIG: extra_q <= reg_wdata & BBRC_EXTRA_CFG_MASK;
        BBRC_OFF_PIN_ENABLE_MASK: bb_pin_select_mask <= reg_wdata;
        BBRC_OFF_SCALING_PIN_SELECT: bb_scaling_pin_pair <= reg_wdata[4:0];
        default: begin
          // alternate codes sit on consecutive addresses
          for (int i = 0; i < BBRC_ALT_COUNT; i++) begin
            if (reg_addr == BBRC_OFF_ALT_VOLTAGE_ZERO + 8'(i)) begin
              alt_q[i] <= reg_wdata[5:0];
            end
          end
        end
      endcase
    end
  end

  // read mux; unmapped addresses and unused bits read zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      BBRC_OFF_ENABLE_CONTROL: rdata_d = {bb_boot_slot, 3'h0, bb_enable_select};
      BBRC_OFF_MAIN_CONFIG: rdata_d = cfg_q;
      BBRC_OFF_VOLTAGE_SETTING: rdata_d = {2'h0, bb_voltage_code};
      BBRC_OFF_PEAK_CURRENT: rdata_d = peak_q;
      BBRC_OFF_EXTRA_CONFIG: rdata_d = extra_q;
      BBRC_OFF_PIN_ENABLE_MASK: rdata_d = bb_pin_select_mask;
      BBRC_OFF_SCALING_PIN_SELECT: rdata_d = {3'h0, bb_scaling_pin_pair};
      BBRC_OFF_APPLIED_READBACK: rdata_d = {2'h0, lnk.applied};
      default: begin
        for (int i = 0; i < BBRC_ALT_COUNT; i++) begin
          if (reg_addr == BBRC_OFF_ALT_VOLTAGE_ZERO + 8'(i)) begin
            rdata_d = {2'h0, alt_q[i]};
          end
        end
      end
    endcase
  end

  // read data held until the next read strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata <= rdata_d;
    end
  end

  // enable source decode
  assign pin_or = |(general_control_pin & bb_pin_select_mask);
  assign sel_off_soft = (bb_boot_slot == BBRC_SLOT_SOFT) && (bb_enable_select == BBRC_SEL_OFF);

  always_comb begin
    en_d = 1'b0;
    case (bb_boot_slot)
      BBRC_SLOT_AT_0: en_d = slot_caught_q;
      BBRC_SLOT_AT_25: en_d = reach_25;
      BBRC_SLOT_AT_50: en_d = reach_50;
      BBRC_SLOT_SOFT: begin
        // software select only counts once the full delay has run
        case (bb_enable_select)
          BBRC_SEL_OFF: en_d = 1'b0;
          BBRC_SEL_ON: en_d = reach_100;
          BBRC_SEL_PINS: en_d = reach_100 && pin_or;
          default: en_d = 1'b0; // reserved select stays off
        endcase
      end
      default: en_d = 1'b0; // off and reserved slots
    endcase
    // a hard reset or off request overrides every source
    if (hard_reset_req || off_mode_req) begin
      en_d = 1'b0;
    end
  end

  // discharge requests; select 00 keeps active discharge off unless reset or off
  assign act_dsc_d = hard_reset_req || off_mode_req
                     || (cfg_q[BBRC_BIT_ACT_DSC] && !en_d && !sel_off_soft);
  assign psv_dsc_d = hard_reset_req || (cfg_q[BBRC_BIT_PSV_DSC] && !en_d);

  // enable and discharge flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_enable <= 1'b0;
      active_discharge <= 1'b0;
      passive_discharge <= 1'b0;
    end else begin
      reg_enable <= en_d;
      active_discharge <= act_dsc_d;
      passive_discharge <= psv_dsc_d;
    end
  end

  // voltage path: nominal or pin-selected alternate code, through the stepper
  assign lnk.pair_cfg = bb_scaling_pin_pair;
  assign lnk.pins = general_control_pin;
  assign lnk.target = lnk.pair_active ? alt_q[lnk.pair_level] : bb_voltage_code;
  assign lnk.ramp_en = cfg_q[BBRC_BIT_RAMP_EN];

  bbrc_pair_decode u_pair (
    .lnk(lnk.pair)
  );

  bbrc_ramp u_ramp (
    .mclk(mclk),
    .rst_n(rst_n),
    .lnk(lnk.ramp)
  );

  // applied code and its scaled value; invalid codes are flagged, not clipped
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      voltage_code <= 6'h00;
      voltage_code_invalid <= 1'b0;
      voltage_mv <= 13'h0000;
      dvs_active <= 1'b0;
    end else begin
      voltage_code <= lnk.applied;
      voltage_code_invalid <= lnk.applied > BBRC_VCODE_MAX;
      voltage_mv <= 13'(BBRC_VOUT_BASE_MV) + 13'(lnk.applied) * 13'(BBRC_VOUT_STEP_MV);
      dvs_active <= lnk.pair_active;
    end
  end

  // peak current source; nibbles only matter when the table is bypassed
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      peak_from_table <= 1'b1;
      nominal_peak_code <= 4'h0;
      max_peak_code <= 5'h00;
      adaptive_disable <= 1'b0;
      valley_fixed_zero <= 1'b0;
    end else begin
      peak_from_table <= !cfg_q[BBRC_BIT_LOOKUP_DIS];
      nominal_peak_code <= peak_q[3:0];
      max_peak_code <= {1'b0, peak_q[3:0]} + {1'b0, peak_q[7:4]};
      adaptive_disable <= extra_q[BBRC_BIT_ADAPT_DIS];
      valley_fixed_zero <= extra_q[BBRC_BIT_ADAPT_DIS];
    end
  end

  // switching stage options
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      buck_only_mode <= 1'b0;
      slow_edge_mode <= 1'b0;
      fast_mode <= 1'b0;
      zero_cross_disable <= 1'b0;
      switch_halving <= 1'b0;
      freq_threshold <= 2'h0;
    end else begin
      buck_only_mode <= cfg_q[BBRC_BIT_OP_MODE];
      slow_edge_mode <= cfg_q[BBRC_BIT_SLOW_EDGE];
      // pin 1 takes over fast mode when handed control
      fast_mode <= extra_q[BBRC_BIT_PIN_FAST] ? general_control_pin[BBRC_PIN_FAST_SRC]
                                              : extra_q[BBRC_BIT_FAST];
      zero_cross_disable <= extra_q[BBRC_BIT_ZC_DIS];
      switch_halving <= extra_q[BBRC_BIT_SW_HALF];
      freq_threshold <= extra_q[1:0];
    end
  end

  sequence s_pin_source;
    (bb_boot_slot == BBRC_SLOT_SOFT) && (bb_enable_select == BBRC_SEL_PINS) && reach_100
      && !hard_reset_req && !off_mode_req;
  endsequence
  property p_pin_enable;
    @(posedge mclk) disable iff (!rst_n) s_pin_source |=> (reg_enable == $past(pin_or));
  endproperty
  a_pin_enable: assert property (p_pin_enable)
    else $error("pin enable is not OR of masked pins");
  property p_select_off;
    @(posedge mclk) disable iff (!rst_n)
      (bb_boot_slot == BBRC_SLOT_SOFT) && (bb_enable_select == BBRC_SEL_OFF) |=> !reg_enable;
  endproperty
  a_select_off: assert property (p_select_off)
    else $error("select 00 left regulator enabled");
  property p_reserved_off;
    @(posedge mclk) disable iff (!rst_n)
      ((bb_boot_slot == BBRC_SLOT_SOFT) && (bb_enable_select == 2'h3))
        || (bb_boot_slot == 3'h1) || (bb_boot_slot == 3'h5)
        || (bb_boot_slot == 3'h6) |=> !reg_enable;
  endproperty
  a_reserved_off: assert property (p_reserved_off)
    else $error("reserved code enabled regulator");
  property p_slot_at_zero;
    @(posedge mclk) disable iff (!rst_n)
      slot_caught_q && (bb_boot_slot == BBRC_SLOT_AT_0) && !hard_reset_req && !off_mode_req
        |=> reg_enable;
  endproperty
  a_slot_at_zero: assert property (p_slot_at_zero)
    else $error("slot 010 not enabled at once");
  property p_active_dsc;
    @(posedge mclk) disable iff (!rst_n)
      cfg_q[BBRC_BIT_ACT_DSC] && !en_d && !sel_off_soft |=> active_discharge;
  endproperty
  a_active_dsc: assert property (p_active_dsc)
    else $error("active discharge missing on enable low");
  property p_select_off_no_dsc;
    @(posedge mclk) disable iff (!rst_n)
      sel_off_soft && !hard_reset_req && !off_mode_req |=> !active_discharge;
  endproperty
  a_select_off_no_dsc: assert property (p_select_off_no_dsc)
    else $error("select 00 caused active discharge");
  property p_passive_dsc;
    @(posedge mclk) disable iff (!rst_n)
      !hard_reset_req && (!cfg_q[BBRC_BIT_PSV_DSC] || en_d) |=> !passive_discharge;
  endproperty
  a_passive_dsc: assert property (p_passive_dsc)
    else $error("passive discharge without cause");
  property p_lookup;
    @(posedge mclk) disable iff (!rst_n)
      ##1 (peak_from_table == !$past(cfg_q[BBRC_BIT_LOOKUP_DIS]));
  endproperty
  a_lookup: assert property (p_lookup)
    else $error("peak source does not follow lookup disable");
  property p_fast_pin;
    @(posedge mclk) disable iff (!rst_n)
      extra_q[BBRC_BIT_PIN_FAST] |=> (fast_mode == $past(general_control_pin[BBRC_PIN_FAST_SRC]));
  endproperty
  a_fast_pin: assert property (p_fast_pin)
    else $error("fast mode not following pin 1");
  property p_dvs_target;
    @(posedge mclk) disable iff (!rst_n)
      lnk.pair_active && !lnk.ramp_en |=> (lnk.applied == $past(alt_q[lnk.pair_level]));
  endproperty
  a_dvs_target: assert property (p_dvs_target)
    else $error("scaling target not from pair level");
  property p_max_peak;
    @(posedge mclk) disable iff (!rst_n)
      ##1 (max_peak_code == {1'b0, $past(peak_q[3:0])} + {1'b0, $past(peak_q[7:4])});
  endproperty
  a_max_peak: assert property (p_max_peak)
    else $error("max peak is not nominal plus increment");
endmodule

//--- test/bbrc_pin_model.sv
// control pin source standing in for the pins outside the regulator
`timescale 1ns/1ns
module bbrc_pin_model (
  input wire logic mclk,
  input wire logic [7:0] pin_req,
  output logic [7:0] general_control_pin
);
  // pins move after a falling edge, well clear of the sampling edge
  // one cycle of lag, as a slow external driver would show
  always @(negedge mclk) begin
    general_control_pin <= pin_req;
  end
endmodule

//--- test/tb_top.sv
// self-checking bench for the buck-boost control bank
`timescale 1ns/1ns
module tb_top
  import bbrc_pkg::*;
;
  logic mclk, reset_n, wr_en, rd_en, hard_req, off_req; // clock, reset, strobes, modes
  logic [7:0] addr, wdata, rdata, pin_req, pins; // register bus and pins
  logic [2:0] strap; // boot slot strap
  logic en, buck, slow, act, psv, inval, tab, adapt, valley, fast, zc, half, dvs;
  logic [5:0] vcode; // applied voltage code
  logic [12:0] vmv; // applied voltage in mV
  logic [3:0] nom; // nominal peak code
  logic [4:0] maxp; // max peak code
  logic [1:0] freq; // frequency threshold
  int miscompares = 0;
  int n_tests = 0;
  // short boot delay keeps the run brief
  bbrc_top #(.BOOT_DELAY_CYCLES(8)) bbrc_top_inst (.mclk(mclk), .reset_n(reset_n),
    .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata(rdata), .boot_slot_strap(strap), .general_control_pin(pins),
    .hard_reset_req(hard_req), .off_mode_req(off_req), .reg_enable(en),
    .buck_only_mode(buck), .slow_edge_mode(slow), .active_discharge(act),
    .passive_discharge(psv), .voltage_code(vcode), .voltage_code_invalid(inval),
    .voltage_mv(vmv), .peak_from_table(tab), .nominal_peak_code(nom),
    .max_peak_code(maxp), .adaptive_disable(adapt), .valley_fixed_zero(valley),
    .fast_mode(fast), .zero_cross_disable(zc), .switch_halving(half),
    .freq_threshold(freq), .dvs_active(dvs));
  bbrc_pin_model bbrc_pin_model_inst (.mclk(mclk), .pin_req(pin_req),
    .general_control_pin(pins));
  // 100 MHz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // one compare; case inequality so unknowns fail
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // write strobe held across one rising edge, then a gap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd_en = 1'b1;
    cyc(1);
    rd_en = 1'b0;
    cyc(1);
    check(16'(rdata), 16'(exp));
  endtask
  // masks, read-only slot, unmapped address
  task automatic t_regs();
    wr(BBRC_OFF_MAIN_CONFIG, 8'hff);
    rd(BBRC_OFF_MAIN_CONFIG, 8'h9f);
    wr(BBRC_OFF_EXTRA_CONFIG, 8'hff);
    rd(BBRC_OFF_EXTRA_CONFIG, 8'h7f);
    wr(BBRC_OFF_ENABLE_CONTROL, 8'hff);
    rd(BBRC_OFF_ENABLE_CONTROL, 8'he3);
    wr(BBRC_OFF_VOLTAGE_SETTING, 8'hff);
    rd(BBRC_OFF_VOLTAGE_SETTING, 8'h3f);
    rd(8'h50, 8'h00);
  endtask
  // every select code, then pins outside the mask
  task automatic t_enable();
    wr(BBRC_OFF_MAIN_CONFIG, 8'h00);
    wr(BBRC_OFF_PIN_ENABLE_MASK, 8'h0c);
    pin_req = 8'h04;
    for (int i = 0; i < 4; i++) begin
      wr(BBRC_OFF_ENABLE_CONTROL, 8'(i));
      cyc(3);
      check(16'(en), 16'(i == 1 || i == 2));
    end
    wr(BBRC_OFF_ENABLE_CONTROL, 8'h02);
    pin_req = 8'h13;
    cyc(4);
    check(16'(en), 16'h0);
  endtask
  // discharge under select 00, pin-off, and forced modes
  task automatic t_discharge();
    wr(BBRC_OFF_MAIN_CONFIG, 8'h09);
    wr(BBRC_OFF_ENABLE_CONTROL, 8'h00);
    cyc(3);
    check(16'({act, psv}), 16'h1);
    wr(BBRC_OFF_ENABLE_CONTROL, 8'h02);
    cyc(3);
    check(16'({act, psv}), 16'h3);
    wr(BBRC_OFF_MAIN_CONFIG, 8'h00);
    wr(BBRC_OFF_ENABLE_CONTROL, 8'h01);
    hard_req = 1'b1;
    cyc(3);
    check(16'({en, act, psv}), 16'h3);
    hard_req = 1'b0;
    off_req = 1'b1;
    cyc(3);
    check(16'({en, act, psv}), 16'h2);
    off_req = 1'b0;
    cyc(3);
    check(16'({en, act, psv}), 16'h4);
  endtask
  // stage option bits, peak fields, all thresholds, pin fast
  task automatic t_stage();
    wr(BBRC_OFF_MAIN_CONFIG, 8'h92);
    wr(BBRC_OFF_PEAK_CURRENT, 8'h35);
    cyc(3);
    check(16'({tab, buck, slow}), 16'h3);
    check(16'({nom, maxp}), 16'h0a8);
    for (int i = 0; i < 4; i++) begin
      wr(BBRC_OFF_EXTRA_CONFIG, 8'h78 | 8'(i));
      cyc(3);
      check(16'({adapt, valley, fast, zc, half, freq}), 16'(124 + i));
    end
    wr(BBRC_OFF_EXTRA_CONFIG, 8'h24);
    pin_req = 8'h00;
    cyc(4);
    check(16'(fast), 16'h0);
    check(16'({adapt, valley, zc, half, freq}), 16'h0);
    pin_req = 8'h02;
    cyc(4);
    check(16'(fast), 16'h1);
  endtask
  // pair 8 is pins 1 and 2, lower pin is bit 0
  task automatic t_dvs();
    for (int i = 0; i < 4; i++) begin
      wr(BBRC_OFF_ALT_VOLTAGE_ZERO + 8'(i), 8'h10 + 8'(i));
    end
    wr(BBRC_OFF_SCALING_PIN_SELECT, 8'h08);
    cyc(3);
    check(16'({dvs, vcode}), 16'h51);
    check(16'(vmv), 16'(2500 + 50 * 17));
    pin_req = 8'h04;
    cyc(4);
    check(16'(vcode), 16'h12);
    wr(BBRC_OFF_SCALING_PIN_SELECT, 8'h1d);
    cyc(3);
    check(16'({dvs, inval, vcode}), 16'h7f);
    rd(BBRC_OFF_APPLIED_READBACK, 8'h3f);
  endtask
  // drop is immediate, rise steps one code per 2000 cycles
  task automatic t_ramp();
    wr(BBRC_OFF_VOLTAGE_SETTING, 8'h03);
    cyc(3);
    check(16'(vcode), 16'h3);
    wr(BBRC_OFF_MAIN_CONFIG, 8'h04);
    wr(BBRC_OFF_VOLTAGE_SETTING, 8'h05);
    cyc(10);
    check(16'(vcode), 16'h3);
    check(16'({tab, buck, slow}), 16'h4);
    cyc(2000);
    check(16'(vcode), 16'h4);
    cyc(2000);
    check(16'(vcode), 16'h5);
    check(16'(vmv), 16'(2750));
  endtask
  // fresh reset with another strap; enable rises n+1 edges after release, or never
  task automatic t_boot(input logic [2:0] s, input int n, input logic on);
    reset_n = 1'b0;
    strap = s;
    cyc(2);
    reset_n = 1'b1;
    cyc(n);
    check(16'(en), 16'h0);
    cyc(1);
    check(16'(en), 16'(on));
  endtask
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // runs about 4210 cycles; hang cut at 20000
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    final_report();
  end
  initial begin
    {reset_n, wr_en, rd_en, hard_req, off_req} = 5'h0;
    {addr, wdata, pin_req} = 24'h0;
    strap = 3'h7;
    cyc(10);
    reset_n = 1'b1;
    cyc(16);
    t_regs();
    t_enable();
    t_discharge();
    t_stage();
    t_dvs();
    t_ramp();
    t_boot(3'h2, 3, 1'b1);
    t_boot(3'h3, 5, 1'b1);
    t_boot(3'h4, 7, 1'b1);
    t_boot(3'h5, 7, 1'b0);
    final_report();
  end
endmodule
